/* File: core/mie_consts.vh */
`ifndef MIE_CONSTS_VH
`define MIE_CONSTS_VH

// ----------------------------------------------------------------
// Register offsets on the host register port
// ----------------------------------------------------------------
`define MIE_ADDR_W 12
`define MIE_OFF_FLAG 12'h004
`define MIE_OFF_MASK 12'h006

// ----------------------------------------------------------------
// Bit positions, shared by flag and enable registers
// ----------------------------------------------------------------
`define MIE_BIT_DSP_OVERRUN 15
`define MIE_BIT_DSP_DONE 14
`define MIE_BIT_REACTIVE_DIR 13
`define MIE_BIT_REAL_DIR 12
`define MIE_BIT_ZX_LOSS 11
`define MIE_BIT_UNDERVOLT 10
`define MIE_BIT_OVERVOLT 9
`define MIE_BIT_OVERCURR 8
`define MIE_BIT_ACCUM_OVF 2
`define MIE_BIT_CHECKSUM 1
`define MIE_BIT_POWER_FAIL 0

// ----------------------------------------------------------------
// Widths, implemented bits and reset values
// ----------------------------------------------------------------
`define MIE_REG_W 16
`define MIE_VALID_BITS 16'hFF07
`define MIE_FLAG_RST 16'h0000
`define MIE_MASK_RST 16'h0000
`define MIE_LVL_W 16

`endif

/* File: core/mie_event_detect.v */
`timescale 1ns/1ps
`include "mie_consts.vh"

module mie_event_detect #(
    parameter NUM_V = 3,
    parameter NUM_I = 4
) (
    input wire clk_sys_in,                       // System clock
    input wire sys_rst_in,                       // Async reset, high
    input wire cycle_start_in,                   // DSP cycle due to begin
    input wire cycle_end_in,                     // DSP cycle completed
    input wire [NUM_V-1:0] zero_cross_in,        // Zero crossing per channel
    input wire v_valid_in,                       // Voltage sample strobe
    input wire [2:0] v_chan_in,                  // Voltage channel index
    input wire [`MIE_LVL_W-1:0] v_abs_in,        // Absolute voltage sample
    input wire i_valid_in,                       // Current sample strobe
    input wire [`MIE_LVL_W-1:0] i_abs_in,        // Absolute current sample
    input wire [`MIE_LVL_W-1:0] undervoltage_threshold_in, // UV trip level
    input wire [`MIE_LVL_W-1:0] overvoltage_threshold_in,  // OV trip level
    input wire [`MIE_LVL_W-1:0] overcurrent_threshold_in,  // OC trip level
    output reg overrun_out,                      // Overrun event pulse
    output reg cycle_done_out,                   // Cycle done event pulse
    output reg zx_loss_out,                      // Zero-cross loss pulse
    output reg undervolt_out,                    // Undervoltage pulse
    output reg overvolt_out,                     // Overvoltage pulse
    output reg overcurr_out                      // Overcurrent pulse
);

    // ----------------------------------------------------------------
    // Per-cycle bookkeeping
    // ----------------------------------------------------------------
    reg busy_q;
    reg [NUM_V-1:0] zx_seen_q;
    reg [NUM_V-1:0] uv_above_q;
    reg [NUM_V-1:0] zx_seen_d;
    reg [NUM_V-1:0] uv_above_d;
    integer k;

    // Include this cycle's samples so the last one is not lost
    always @* begin
        zx_seen_d = zx_seen_q | zero_cross_in;
        uv_above_d = uv_above_q;
        for (k = 0; k < NUM_V; k = k + 1) begin
            if (v_valid_in && (v_chan_in == k[2:0]) &&
                (v_abs_in > undervoltage_threshold_in)) begin
                uv_above_d[k] = 1'b1;
            end
        end
    end

    // Channel sets are reset at each cycle end for the next cycle
    always @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            busy_q <= 1'b0;
            zx_seen_q <= {NUM_V{1'b0}};
            uv_above_q <= {NUM_V{1'b0}};
            overrun_out <= 1'b0;
            cycle_done_out <= 1'b0;
            zx_loss_out <= 1'b0;
            undervolt_out <= 1'b0;
            overvolt_out <= 1'b0;
            overcurr_out <= 1'b0;
        end else begin
            // Start while previous cycle still running is an overrun
            overrun_out <= cycle_start_in & busy_q & ~cycle_end_in;
            cycle_done_out <= cycle_end_in;
            if (cycle_start_in) begin
                busy_q <= 1'b1;
            end else if (cycle_end_in) begin
                busy_q <= 1'b0;
            end
            zx_loss_out <= cycle_end_in & ~(&zx_seen_d);
            undervolt_out <= cycle_end_in & ~(&uv_above_d);
            overvolt_out <= v_valid_in &
                (v_abs_in > overvoltage_threshold_in);
            overcurr_out <= i_valid_in &
                (i_abs_in > overcurrent_threshold_in);
            if (cycle_end_in) begin
                zx_seen_q <= {NUM_V{1'b0}};
                uv_above_q <= {NUM_V{1'b0}};
            end else begin
                zx_seen_q <= zx_seen_d;
                uv_above_q <= uv_above_d;
            end
        end
    end

endmodule

/* File: core/mie_irq_enable_mask.v */
// Functional notes
// - Enables 15 and 14 gate DSP-overrun and cycle-done flags onto IRQ.
// - Enable 13 gates reactive energy direction reversal onto IRQ.
// - Enable 12 gates real energy direction reversal onto IRQ.
// - Enable 11 gates missing zero crossing for a DSP cycle.
// - Enable 10 gates channel never above undervoltage level in a cycle.
// - Enable 9 gates any voltage sample above overvoltage level.
// - Enable 8 gates any current sample above overcurrent level.
// - Enable 2 gates energy accumulator MSB overflow onto IRQ.
// - Enable 1 gates configuration checksum change onto IRQ.
// - Enable 0 gates imminent supply failure onto IRQ.
// - Flags sit at enable positions; host clears them, IRQ holds till then.
// - Overrun flag sets when a cycle is due while one still runs.
// - Cycle-done flag sets every time a DSP cycle completes.
`timescale 1ns/1ps
`include "mie_consts.vh"

module mie_irq_enable_mask #(
    parameter NUM_V = 3,
    parameter NUM_I = 4,
    parameter NUM_ACC = 8
) (
    input wire clk_sys_in,                       // System clock, 250 MHz
    input wire sys_rst_in,                       // Async reset, high
    input wire [`MIE_ADDR_W-1:0] reg_addr_in,    // Register address
    input wire reg_wr_in,                        // Register write strobe
    input wire [`MIE_REG_W-1:0] reg_wdata_in,    // Register write data
    input wire reg_rd_in,                        // Register read strobe
    output reg [`MIE_REG_W-1:0] reg_rdata_out,   // Read data, next cycle
    output reg reg_rvalid_out,                   // Read data valid pulse
    output reg irq_n_out,                        // Interrupt request, low
    input wire cycle_start_in,                   // DSP cycle due to begin
    input wire cycle_end_in,                     // DSP cycle completed
    input wire [NUM_V-1:0] zero_cross_in,        // Zero crossing pulses
    input wire v_valid_in,                       // Voltage sample strobe
    input wire [2:0] v_chan_in,                  // Voltage channel index
    input wire [`MIE_LVL_W-1:0] v_abs_in,        // Absolute voltage
    input wire i_valid_in,                       // Current sample strobe
    input wire [`MIE_LVL_W-1:0] i_abs_in,        // Absolute current
    input wire [`MIE_LVL_W-1:0] undervoltage_threshold_in, // UV level
    input wire [`MIE_LVL_W-1:0] overvoltage_threshold_in,  // OV level
    input wire [`MIE_LVL_W-1:0] overcurrent_threshold_in,  // OC level
    input wire energy_valid_in,                  // Energy sign update strobe
    input wire reactive_sign_in,                 // 1 = capacitive
    input wire real_sign_in,                     // 1 = away from load
    input wire [NUM_ACC-1:0] accum_ovf_in,       // Accumulator MSB overflow
    input wire checksum_valid_in,                // New checksum computed
    input wire [`MIE_REG_W-1:0] config_checksum_in, // Checksum value
    input wire power_fail_in                     // Supply monitor pin, high
);

    // ----------------------------------------------------------------
    // Address decode helper
    // ----------------------------------------------------------------
    function hit;
        input [`MIE_ADDR_W-1:0] addr;
        input [`MIE_ADDR_W-1:0] off;
        begin
            hit = (addr == off);
        end
    endfunction

    // ----------------------------------------------------------------
    // Cycle and level based events
    // ----------------------------------------------------------------
    wire ev_overrun;
    wire ev_done;
    wire ev_zx_loss;
    wire ev_undervolt;
    wire ev_overvolt;
    wire ev_overcurr;

    mie_event_detect #(
        .NUM_V(NUM_V),
        .NUM_I(NUM_I)
    ) u_detect (
        .clk_sys_in(clk_sys_in),
        .sys_rst_in(sys_rst_in),
        .cycle_start_in(cycle_start_in),
        .cycle_end_in(cycle_end_in),
        .zero_cross_in(zero_cross_in),
        .v_valid_in(v_valid_in),
        .v_chan_in(v_chan_in),
        .v_abs_in(v_abs_in),
        .i_valid_in(i_valid_in),
        .i_abs_in(i_abs_in),
        .undervoltage_threshold_in(undervoltage_threshold_in),
        .overvoltage_threshold_in(overvoltage_threshold_in),
        .overcurrent_threshold_in(overcurrent_threshold_in),
        .overrun_out(ev_overrun),
        .cycle_done_out(ev_done),
        .zx_loss_out(ev_zx_loss),
        .undervolt_out(ev_undervolt),
        .overvolt_out(ev_overvolt),
        .overcurr_out(ev_overcurr)
    );

    // ----------------------------------------------------------------
    // Energy direction tracking
    // ----------------------------------------------------------------
    reg dir_seen_q;
    reg reactive_prev_q;
    reg real_prev_q;
    wire ev_reactive_dir;
    wire ev_real_dir;

    // First update only primes the history, it is not a reversal
    assign ev_reactive_dir = energy_valid_in & dir_seen_q &
        (reactive_sign_in != reactive_prev_q);
    assign ev_real_dir = energy_valid_in & dir_seen_q &
        (real_sign_in != real_prev_q);

    // Sign history, only moved on an update strobe
    always @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            dir_seen_q <= 1'b0;
            reactive_prev_q <= 1'b0;
            real_prev_q <= 1'b0;
        end else if (energy_valid_in) begin
            dir_seen_q <= 1'b1;
            reactive_prev_q <= reactive_sign_in;
            real_prev_q <= real_sign_in;
        end
    end

    // ----------------------------------------------------------------
    // Checksum change detection
    // ----------------------------------------------------------------
    reg cks_seen_q;
    reg [`MIE_REG_W-1:0] cks_q;
    wire ev_checksum;

    assign ev_checksum = checksum_valid_in & cks_seen_q &
        (config_checksum_in != cks_q);

    // Holds last checksum for comparison
    always @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cks_seen_q <= 1'b0;
            cks_q <= {`MIE_REG_W{1'b0}};
        end else if (checksum_valid_in) begin
            cks_seen_q <= 1'b1;
            cks_q <= config_checksum_in;
        end
    end

    // ----------------------------------------------------------------
    // Power-fail pin synchroniser and filter
    // ----------------------------------------------------------------
    reg pf_s1_q;
    reg pf_s2_q;
    reg pf_s3_q;
    reg pf_stable_q;
    wire pf_agree;
    wire ev_power_fail;

    // Stage one feeds stage two only; change counts once two and three agree
    assign pf_agree = (pf_s2_q == pf_s3_q);
    assign ev_power_fail = pf_agree & pf_s2_q & ~pf_stable_q;

    always @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pf_s1_q <= 1'b0;
            pf_s2_q <= 1'b0;
            pf_s3_q <= 1'b0;
            pf_stable_q <= 1'b0;
        end else begin
            pf_s1_q <= power_fail_in;
            pf_s2_q <= pf_s1_q;
            pf_s3_q <= pf_s2_q;
            if (pf_agree) begin
                pf_stable_q <= pf_s2_q;
            end
        end
    end

    // ----------------------------------------------------------------
    // Event vector at flag positions
    // ----------------------------------------------------------------
    reg [`MIE_REG_W-1:0] set_vec;

    always @* begin
        set_vec = {`MIE_REG_W{1'b0}};
        set_vec[`MIE_BIT_DSP_OVERRUN] = ev_overrun;
        set_vec[`MIE_BIT_DSP_DONE] = ev_done;
        set_vec[`MIE_BIT_REACTIVE_DIR] = ev_reactive_dir;
        set_vec[`MIE_BIT_REAL_DIR] = ev_real_dir;
        set_vec[`MIE_BIT_ZX_LOSS] = ev_zx_loss;
        set_vec[`MIE_BIT_UNDERVOLT] = ev_undervolt;
        set_vec[`MIE_BIT_OVERVOLT] = ev_overvolt;
        set_vec[`MIE_BIT_OVERCURR] = ev_overcurr;
        set_vec[`MIE_BIT_ACCUM_OVF] = |accum_ovf_in;
        set_vec[`MIE_BIT_CHECKSUM] = ev_checksum;
        set_vec[`MIE_BIT_POWER_FAIL] = ev_power_fail;
    end

    // ----------------------------------------------------------------
    // Flag and enable registers
    // ----------------------------------------------------------------
    reg [`MIE_REG_W-1:0] flag_q;
    reg [`MIE_REG_W-1:0] flag_d;
    reg [`MIE_REG_W-1:0] mask_q;
    reg [`MIE_REG_W-1:0] mask_d;
    wire wr_flag;
    wire wr_mask;

    assign wr_flag = reg_wr_in & hit(reg_addr_in, `MIE_OFF_FLAG);
    assign wr_mask = reg_wr_in & hit(reg_addr_in, `MIE_OFF_MASK);

    // Write one to clear; a new event in the same cycle wins
    always @* begin
        flag_d = flag_q;
        if (wr_flag) begin
            flag_d = flag_q & ~reg_wdata_in;
        end
        flag_d = (flag_d | set_vec) & `MIE_VALID_BITS;
        mask_d = mask_q;
        if (wr_mask) begin
            mask_d = reg_wdata_in & `MIE_VALID_BITS;
        end
    end

    always @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            flag_q <= `MIE_FLAG_RST;
            mask_q <= `MIE_MASK_RST;
        end else begin
            flag_q <= flag_d;
            mask_q <= mask_d;
        end
    end

    // ----------------------------------------------------------------
    // Interrupt request pin
    // ----------------------------------------------------------------
    // Built from next values so the pin tracks the registers exactly
    always @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            irq_n_out <= 1'b1;
        end else begin
            irq_n_out <= ~|(flag_d & mask_d & `MIE_VALID_BITS);
        end
    end

    // ----------------------------------------------------------------
    // Register read port
    // ----------------------------------------------------------------
    // Unmapped addresses read as zero; reads have no side effect
    always @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            reg_rdata_out <= {`MIE_REG_W{1'b0}};
            reg_rvalid_out <= 1'b0;
        end else begin
            reg_rvalid_out <= reg_rd_in;
            if (reg_rd_in && hit(reg_addr_in, `MIE_OFF_FLAG)) begin
                reg_rdata_out <= flag_q;
            end else if (reg_rd_in && hit(reg_addr_in, `MIE_OFF_MASK)) begin
                reg_rdata_out <= mask_q;
            end else begin
                reg_rdata_out <= {`MIE_REG_W{1'b0}};
            end
        end
    end

endmodule

/* File: sim/mie_host_model.sv */
`timescale 1ns/1ps
`include "mie_consts.vh"

module mie_host_model (
    input wire clk_sys_in,                 // Clock
    output reg [11:0] reg_addr_out,        // Address
    output reg reg_wr_out,                 // Write strobe
    output reg [15:0] reg_wdata_out,       // Write data
    output reg reg_rd_out,                 // Read strobe
    input wire [15:0] reg_rdata_in,        // Read data
    input wire reg_rvalid_in               // Read valid
);
    // Idle bus carries junk, never a stale access
    initial begin
        reg_addr_out = 12'hFFF;
        reg_wr_out = 1'b0;
        reg_wdata_out = 16'hA5A5;
        reg_rd_out = 1'b0;
    end

    // One-cycle write strobe; address inverted once released
    task wr(input [11:0] a, input [15:0] d);
        @(posedge clk_sys_in);
        reg_addr_out <= a;
        reg_wdata_out <= d;
        reg_wr_out <= 1'b1;
        @(posedge clk_sys_in);
        reg_wr_out <= 1'b0;
        reg_addr_out <= ~a;
        reg_wdata_out <= ~d;
    endtask

    // Answer stands the cycle after the taking edge
    task rd(input [11:0] a, output [15:0] d, output v);
        @(posedge clk_sys_in);
        reg_addr_out <= a;
        reg_rd_out <= 1'b1;
        @(posedge clk_sys_in);
        reg_rd_out <= 1'b0;
        reg_addr_out <= ~a;
        #1;
        v = reg_rvalid_in;
        d = reg_rdata_in;
    endtask

    // Host owes a clear of every flag it has handled
    task clr(input [15:0] bits);
        wr(`MIE_OFF_FLAG, bits);
    endtask
endmodule

/* File: sim/mie_irq_chk_asserts.sv */
`timescale 1ns/1ps
`include "mie_consts.vh"

module mie_irq_chk #(
    parameter NUM_ACC = 8
) (
    input wire clk_sys_in,                       // Clock
    input wire sys_rst_in,                       // Async reset
    input wire [`MIE_ADDR_W-1:0] reg_addr_in,    // Address
    input wire reg_wr_in,                        // Write strobe
    input wire [`MIE_REG_W-1:0] reg_wdata_in,    // Write data
    input wire reg_rd_in,                        // Read strobe
    input wire [`MIE_REG_W-1:0] reg_rdata_out,   // Read data
    input wire reg_rvalid_out,                   // Read valid
    input wire irq_n_out,                        // Interrupt, low
    input wire cycle_end_in,                     // Cycle completed
    input wire v_valid_in,                       // Voltage strobe
    input wire [`MIE_LVL_W-1:0] v_abs_in,        // Voltage sample
    input wire [`MIE_LVL_W-1:0] overvoltage_threshold_in, // OV level
    input wire i_valid_in,                       // Current strobe
    input wire [`MIE_LVL_W-1:0] i_abs_in,        // Current sample
    input wire [`MIE_LVL_W-1:0] overcurrent_threshold_in, // OC level
    input wire [NUM_ACC-1:0] accum_ovf_in,       // Overflow pulses
    input wire power_fail_in                     // Supply monitor
);
    // ----------------------------------------------------------------
    // Enable shadow, rebuilt from host writes
    // ----------------------------------------------------------------
    reg [15:0] mask_q;
    wire mask_wr = reg_wr_in && reg_addr_in == `MIE_OFF_MASK;
    wire mapped = reg_addr_in == `MIE_OFF_MASK ||
                  reg_addr_in == `MIE_OFF_FLAG;

    // Reserved bits dropped so the shadow matches what reads return
    always @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            mask_q <= 16'h0000;
        end else if (mask_wr) begin
            mask_q <= reg_wdata_in & `MIE_VALID_BITS;
        end
    end

    // ----------------------------------------------------------------
    // Port relations
    // ----------------------------------------------------------------
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (sys_rst_in);

    read_answer_a: assert property (reg_rd_in |=> reg_rvalid_out)
        else $error("read strobe got no answer");
    quiet_bus_a: assert property (!reg_rd_in |=>
        !reg_rvalid_out && reg_rdata_out == 16'h0000)
        else $error("read data without a read");
    mask_readback_a: assert property (reg_rd_in &&
        reg_addr_in == `MIE_OFF_MASK |=> reg_rdata_out == $past(mask_q))
        else $error("enable readback wrong");
    unmapped_zero_a: assert property (reg_rd_in && !mapped |=>
        reg_rdata_out == 16'h0000)
        else $error("unmapped read not zero");
    reserved_bits_a: assert property (reg_rvalid_out |->
        reg_rdata_out[7:3] == 5'h00)
        else $error("reserved bits read nonzero");
    no_enable_a: assert property (mask_q == 16'h0000 |-> irq_n_out)
        else $error("interrupt with nothing enabled");
    accum_irq_a: assert property (|accum_ovf_in && mask_q[2] &&
        !mask_wr |=> !irq_n_out)
        else $error("overflow did not interrupt");
    done_irq_a: assert property (cycle_end_in && mask_q[14] &&
        !mask_wr |-> ##[1:3] !irq_n_out)
        else $error("cycle done did not interrupt");
    ov_irq_a: assert property (v_valid_in && mask_q[9] &&
        v_abs_in > overvoltage_threshold_in |-> ##[1:3] !irq_n_out)
        else $error("overvoltage did not interrupt");
    oc_irq_a: assert property (i_valid_in && mask_q[8] &&
        i_abs_in > overcurrent_threshold_in |-> ##[1:3] !irq_n_out)
        else $error("overcurrent did not interrupt");
    pwr_irq_a: assert property ($rose(power_fail_in) &&
        mask_q[0] |-> ##[1:5] !irq_n_out)
        else $error("power fail did not interrupt");

    cover property (!irq_n_out && mask_q[14]);
    cover property (reg_rvalid_out && reg_rdata_out != 16'h0000);
    cover property ($rose(power_fail_in) && mask_q[0]);
endmodule

bind mie_irq_enable_mask mie_irq_chk #(.NUM_ACC(NUM_ACC)) u_mie_irq_chk (
    .clk_sys_in, .sys_rst_in, .reg_addr_in, .reg_wr_in, .reg_wdata_in,
    .reg_rd_in, .reg_rdata_out, .reg_rvalid_out, .irq_n_out, .cycle_end_in,
    .v_valid_in, .v_abs_in, .overvoltage_threshold_in, .i_valid_in,
    .i_abs_in, .overcurrent_threshold_in, .accum_ovf_in, .power_fail_in);

/* File: sim/mie_irq_enable_mask_bench.sv */
`timescale 1ns/1ps
`include "mie_consts.vh"
`define CHK(got, exp) begin \
    compares++; \
    if ((got) !== (exp)) begin \
        errors++; \
        $display("FAIL t=%0t got=%h exp=%h", $time, got, exp); \
    end \
end

module mie_irq_enable_mask_bench;
    // Expected flags per event kind, kind 0 in the low word
    localparam [175:0] TAB = {16'h0001, 16'h1000, 16'h2000, 16'h0002,
        16'h0004, 16'h0100, 16'h0200, 16'h4400, 16'h4800, 16'h4000,
        16'hC000};
    reg clk_sys_in;
    reg sys_rst_in;
    wire [11:0] reg_addr_in;
    wire reg_wr_in, reg_rd_in, reg_rvalid_out, irq_n_out;
    wire [15:0] reg_wdata_in, reg_rdata_out;
    reg cycle_start_in, cycle_end_in, v_valid_in, i_valid_in;
    reg energy_valid_in, reactive_sign_in, real_sign_in;
    reg checksum_valid_in, power_fail_in;
    reg [2:0] zero_cross_in, v_chan_in;
    reg [15:0] v_abs_in, i_abs_in, config_checksum_in, e, m;
    reg [15:0] undervoltage_threshold_in, overvoltage_threshold_in;
    reg [15:0] overcurrent_threshold_in;
    reg [7:0] accum_ovf_in;
    int errors, compares;

    mie_irq_enable_mask u_mie_irq_enable_mask (
        .clk_sys_in, .sys_rst_in, .reg_addr_in, .reg_wr_in, .reg_wdata_in,
        .reg_rd_in, .reg_rdata_out, .reg_rvalid_out, .irq_n_out,
        .cycle_start_in, .cycle_end_in, .zero_cross_in, .v_valid_in,
        .v_chan_in, .v_abs_in, .i_valid_in, .i_abs_in,
        .undervoltage_threshold_in, .overvoltage_threshold_in,
        .overcurrent_threshold_in, .energy_valid_in, .reactive_sign_in,
        .real_sign_in, .accum_ovf_in, .checksum_valid_in,
        .config_checksum_in, .power_fail_in);

    mie_host_model u_mie_host_model (.clk_sys_in,
        .reg_addr_out(reg_addr_in), .reg_wr_out(reg_wr_in),
        .reg_wdata_out(reg_wdata_in), .reg_rd_out(reg_rd_in),
        .reg_rdata_in(reg_rdata_out), .reg_rvalid_in(reg_rvalid_out));

    // 250 MHz clock
    initial begin
        clk_sys_in = 1'b0;
        forever #2 clk_sys_in = ~clk_sys_in;
    end

    task close_out;
        $display("Comparisons %0d, mismatches %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task rdchk(input [11:0] a, input [15:0] x);
        reg [15:0] d;
        reg v;
        u_mie_host_model.rd(a, d, v);
        `CHK(v, 1'b1)
        `CHK(d, x)
    endtask

    // One DSP cycle; zero crossings and samples each switched on or off for all three channels together
    task cyc(input bit zon, input bit son);
        @(posedge clk_sys_in);
        cycle_start_in <= 1'b1;
        for (int c = 0; c < 3; c++) begin
            @(posedge clk_sys_in);
            cycle_start_in <= 1'b0;
            zero_cross_in <= {3{zon}} & (3'h1 << c);
            v_valid_in <= son;
            v_chan_in <= c[2:0];
            v_abs_in <= 16'h0100;
        end
        @(posedge clk_sys_in);
        {v_valid_in, zero_cross_in} <= 4'h0;
        cycle_end_in <= 1'b1;
        @(posedge clk_sys_in);
        cycle_end_in <= 1'b0;
    endtask

    // Raise the event of kind k, then drop every strobe
    task fire(input int k);
        reg [15:0] r;
        r = 16'($urandom);
        @(posedge clk_sys_in);
        case (k)
            0: begin
                cycle_start_in <= 1'b1;
                cyc(1, 1);
            end
            1: cyc(1, 1);
            2: cyc(0, 1);
            3: cyc(1, 0);
            4: begin
                v_valid_in <= 1'b1;
                v_chan_in <= 3'(r % 3);
                v_abs_in <= 16'hF800 | r;
            end
            5: begin
                i_valid_in <= 1'b1;
                i_abs_in <= 16'h8000 | r;
            end
            6: accum_ovf_in <= r[7:0] | 8'h01;
            7: begin
                checksum_valid_in <= 1'b1;
                config_checksum_in <= r;
                @(posedge clk_sys_in);
                config_checksum_in <= ~r;
            end
            10: begin
                power_fail_in <= 1'b1;
                repeat (6) @(posedge clk_sys_in);
            end
            default: begin
                energy_valid_in <= 1'b1;
                {reactive_sign_in, real_sign_in} <= k == 8 ? 2'b00 : 2'b10;
                @(posedge clk_sys_in);
                {reactive_sign_in, real_sign_in} <= k == 8 ? 2'b10 : 2'b11;
            end
        endcase
        @(posedge clk_sys_in);
        {v_valid_in, i_valid_in, checksum_valid_in} <= 3'h0;
        {energy_valid_in, power_fail_in, accum_ovf_in} <= 10'h000;
    endtask

    // Hang guard, about twenty times the expected run
    initial begin
        #40000;
        errors++;
        close_out;
    end

    initial begin
        void'($urandom(32'h568C6BDD));
        errors = 0;
        compares = 0;
        {cycle_start_in, cycle_end_in, v_valid_in, i_valid_in} = 4'h0;
        {energy_valid_in, reactive_sign_in, real_sign_in} = 3'h0;
        {checksum_valid_in, power_fail_in, zero_cross_in, v_chan_in} = 8'h00;
        {v_abs_in, i_abs_in, config_checksum_in} = 48'h0;
        accum_ovf_in = 8'h00;
        undervoltage_threshold_in = 16'h0010;
        overvoltage_threshold_in = 16'hF000;
        overcurrent_threshold_in = 16'h7FFF;
        sys_rst_in = 1'b1;
        repeat (8) @(posedge clk_sys_in);
        sys_rst_in <= 1'b0;
        rdchk(`MIE_OFF_MASK, `MIE_MASK_RST);
        rdchk(`MIE_OFF_FLAG, `MIE_FLAG_RST);
        `CHK(irq_n_out, 1'b1)
        m = 16'($urandom);
        u_mie_host_model.wr(`MIE_OFF_MASK, m);
        u_mie_host_model.wr(12'h008, ~m);
        rdchk(`MIE_OFF_MASK, m & `MIE_VALID_BITS);
        rdchk(12'h005, 16'h0000);
        // Each event enabled alone, then with every other enable set
        for (int k = 0; k < 11; k++) begin
            for (int p = 0; p < 2; p++) begin
                e = TAB[k*16 +: 16];
                m = p ? ~e & `MIE_VALID_BITS : e;
                u_mie_host_model.wr(`MIE_OFF_MASK, m);
                fire(k);
                repeat (6) @(posedge clk_sys_in);
                #1;
                `CHK(irq_n_out, (e & m) == 16'h0000)
                rdchk(`MIE_OFF_FLAG, e);
                if (k == 0) begin
                    u_mie_host_model.clr(16'h4000);
                    rdchk(`MIE_OFF_FLAG, 16'h8000);
                end
                u_mie_host_model.clr(16'hFFFF);
                rdchk(`MIE_OFF_FLAG, 16'h0000);
                `CHK(irq_n_out, 1'b1)
            end
        end
        close_out;
    end
endmodule
